// [core/mrsc_core.sv]
//----------------------------------------------------------------------
// Summary of operation
//----------------------------------------------------------------------
// Summary of operation
// - Power-on reset clears program counter
// - Power-on presets port data, direction high
// - Filtered supply low gives reset, flag
// - Short supply dips are ignored
// - Select code enables, disables, else resets
// - Bad select code resets after delay
// - Bad code sets error flag, software clears
// - Select register powers up enabled
// - No supply reset in sleep or idle
// - Supply reset keeps select register
// - Supply flag sticky until software clears
// - Upper five flag bits read zero
// - Awake watchdog timeout resets, sets flag
// - Asleep timeout clears only PC, SP
// - Bad watchdog code sets its flag
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

module mrsc_core
#(
	parameter int LVR_FILTER_CYC = mrsc_pkg::MRSC_LVR_FILTER_CYC,
	parameter int SRESET_CYC     = mrsc_pkg::MRSC_SRESET_CYC,
	parameter int RSTD_CYC       = mrsc_pkg::MRSC_RSTD_CYC
)
(
	// Clock and reset
	input  wire logic                   ref_clk_in,
	input  wire logic                   rst_n_in,
	// Event sources
	input  wire logic                   supply_low_in,
	input  wire logic                   wdt_overflow_in,
	input  wire logic [4:0]             wdt_control_in,
	input  wire mrsc_pkg::mrsc_mode_type power_mode_in,
	// Reset actions
	output mrsc_pkg::mrsc_reset_type    reset_out,
	output logic                        lvd_enable_out,
	output logic                        timeout_status_flag_out,
	// AXI4-Lite write address and data
	input  wire logic [3:0]             s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	// AXI4-Lite read
	input  wire logic [3:0]             s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready
);

	localparam int CW = 16;

	// Saturating count helper
	function automatic logic [CW-1:0] count_up(input logic [CW-1:0] v, input int lim);
		count_up = (v >= lim[CW-1:0]) ? v : v + 16'h0001;
	endfunction

	//------------------------------------------------------------------
	// Input synchronisers
	//------------------------------------------------------------------
	logic [2:0] low_sync_q;
	logic [2:0] low_sync_d;
	logic [2:0] wdt_sync_q;
	logic [2:0] wdt_sync_d;
	logic       low_s_q;
	logic       low_s_d;
	logic       wdt_s_q;
	logic       wdt_s_d;

	// Shift chains; a change counts once stages two and three agree
	always_comb
	begin
		low_sync_d = {low_sync_q[1:0], supply_low_in};
		wdt_sync_d = {wdt_sync_q[1:0], wdt_overflow_in};
		low_s_d    = (low_sync_q[1] == low_sync_q[2]) ? low_sync_q[2] : low_s_q;
		wdt_s_d    = (wdt_sync_q[1] == wdt_sync_q[2]) ? wdt_sync_q[2] : wdt_s_q;
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			low_sync_q <= 3'h0;
			wdt_sync_q <= 3'h0;
			low_s_q    <= 1'b0;
			wdt_s_q    <= 1'b0;
		end
		else
		begin
			low_sync_q <= low_sync_d;
			wdt_sync_q <= wdt_sync_d;
			low_s_q    <= low_s_d;
			wdt_s_q    <= wdt_s_d;
		end
	end

	//------------------------------------------------------------------
	// Event detection
	//------------------------------------------------------------------
	logic [7:0]                low_voltage_select_q;
	logic [7:0]                low_voltage_select_d;
	logic [CW-1:0]             lvr_cnt_q;
	logic [CW-1:0]             lvr_cnt_d;
	logic [CW-1:0]             lsel_cnt_q;
	logic [CW-1:0]             lsel_cnt_d;
	logic [CW-1:0]             wsel_cnt_q;
	logic [CW-1:0]             wsel_cnt_d;
	logic                      wdt_s_prev_q;
	logic                      asleep;
	logic                      lvs_bad;
	logic                      wdc_bad;
	logic                      ev_lvr;
	logic                      ev_lsel;
	logic                      ev_wsel;
	logic                      ev_wdt;

	always_comb
	begin
		asleep         = (power_mode_in == mrsc_pkg::MRSC_MODE_IDLE) ||
		                 (power_mode_in == mrsc_pkg::MRSC_MODE_SLEEP);
		lvd_enable_out = (low_voltage_select_q == mrsc_pkg::MRSC_LVS_ENABLE) && !asleep;
		lvs_bad        = (low_voltage_select_q != mrsc_pkg::MRSC_LVS_ENABLE) &&
		                 (low_voltage_select_q != mrsc_pkg::MRSC_LVS_DISABLE);
		wdc_bad        = (wdt_control_in != mrsc_pkg::MRSC_WDC_ENABLE) &&
		                 (wdt_control_in != mrsc_pkg::MRSC_WDC_DISABLE);
		// Supply low must persist beyond the filter time
		lvr_cnt_d      = (low_s_q && lvd_enable_out) ? count_up(lvr_cnt_q, LVR_FILTER_CYC + 1) : '0;
		ev_lvr         = (lvr_cnt_q == LVR_FILTER_CYC[CW-1:0]) && low_s_q && lvd_enable_out;
		// Bad codes wait out the software reset delay
		lsel_cnt_d     = lvs_bad ? count_up(lsel_cnt_q, SRESET_CYC + 1) : '0;
		ev_lsel        = lvs_bad && (lsel_cnt_q == SRESET_CYC[CW-1:0]);
		wsel_cnt_d     = wdc_bad ? count_up(wsel_cnt_q, SRESET_CYC + 1) : '0;
		ev_wsel        = wdc_bad && (wsel_cnt_q == SRESET_CYC[CW-1:0]);
		ev_wdt         = wdt_s_q && !wdt_s_prev_q;
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			lvr_cnt_q    <= '0;
			lsel_cnt_q   <= '0;
			wsel_cnt_q   <= '0;
			wdt_s_prev_q <= 1'b0;
		end
		else
		begin
			lvr_cnt_q    <= lvr_cnt_d;
			lsel_cnt_q   <= lsel_cnt_d;
			wsel_cnt_q   <= wsel_cnt_d;
			wdt_s_prev_q <= wdt_s_q;
		end
	end

	//------------------------------------------------------------------
	// Reset sequencer
	//------------------------------------------------------------------
	mrsc_pkg::mrsc_state_type state_q;
	mrsc_pkg::mrsc_state_type state_d;
	logic [CW-1:0]            rstd_cnt_q;
	logic [CW-1:0]            rstd_cnt_d;
	logic                     full_req;
	logic                     por_q;
	logic                     por_d;
	logic                     light_q;
	logic                     light_d;

	// Full resets come from supply, bad codes and awake timeout
	always_comb
	begin
		full_req   = ev_lvr || ev_lsel || ev_wsel || (ev_wdt && !asleep);
		state_d    = state_q;
		rstd_cnt_d = rstd_cnt_q;
		por_d      = por_q;
		light_d    = ev_wdt && asleep;
		unique case (state_q)
			mrsc_pkg::MRSC_ST_RUN:
			begin
				por_d = 1'b0;
				if (full_req)
					state_d = mrsc_pkg::MRSC_ST_HOLD;
			end
			mrsc_pkg::MRSC_ST_HOLD:
			begin
				rstd_cnt_d = '0;
				state_d    = mrsc_pkg::MRSC_ST_WAIT;
			end
			mrsc_pkg::MRSC_ST_WAIT:
			begin
				// Hold core reset for the start-up delay
				rstd_cnt_d = count_up(rstd_cnt_q, RSTD_CYC);
				if (full_req)
					rstd_cnt_d = '0;
				else if (rstd_cnt_q >= RSTD_CYC[CW-1:0] - 16'h0001)
					state_d = mrsc_pkg::MRSC_ST_RUN;
			end
			default:
				state_d = mrsc_pkg::MRSC_ST_HOLD;
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state_q    <= mrsc_pkg::MRSC_ST_HOLD;
			rstd_cnt_q <= '0;
			por_q      <= 1'b1;
			light_q    <= 1'b0;
		end
		else
		begin
			state_q    <= state_d;
			rstd_cnt_q <= rstd_cnt_d;
			por_q      <= por_d;
			light_q    <= light_d;
		end
	end

	// Reset action outputs
	always_comb
	begin
		reset_out.core_reset   = (state_q != mrsc_pkg::MRSC_ST_RUN);
		reset_out.pc_clear     = reset_out.core_reset || light_q;
		reset_out.sp_clear     = reset_out.core_reset || light_q;
		reset_out.ports_preset = reset_out.core_reset;
	end

	//------------------------------------------------------------------
	// Registers and AXI4-Lite slave
	//------------------------------------------------------------------
	logic [2:0]  flags_q;
	logic [2:0]  flags_d;
	logic        to_q;
	logic        to_d;
	logic        bvalid_q;
	logic        bvalid_d;
	logic [1:0]  bresp_q;
	logic [1:0]  bresp_d;
	logic        rvalid_q;
	logic        rvalid_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [1:0]  rresp_q;
	logic [1:0]  rresp_d;
	logic        wr_go;
	logic        rd_go;

	always_comb
	begin
		wr_go         = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
		rd_go         = s_axi_arvalid && !rvalid_q;
		s_axi_awready = wr_go;
		s_axi_wready  = wr_go;
		s_axi_arready = rd_go;
		low_voltage_select_d = low_voltage_select_q;
		flags_d       = flags_q;
		to_d          = to_q;
		bvalid_d      = bvalid_q && !s_axi_bready;
		bresp_d       = bresp_q;
		rvalid_d      = rvalid_q && !s_axi_rready;
		rdata_d       = rdata_q;
		rresp_d       = rresp_q;
		// Software writes, byte lane zero
		if (wr_go)
		begin
			bvalid_d = 1'b1;
			bresp_d  = mrsc_pkg::MRSC_RESP_OKAY;
			if (s_axi_awaddr == mrsc_pkg::MRSC_LVS_OFFSET)
			begin
				if (s_axi_wstrb[0])
					low_voltage_select_d = s_axi_wdata[7:0];
			end
			else if (s_axi_awaddr == mrsc_pkg::MRSC_FLAGS_OFFSET)
			begin
				if (s_axi_wstrb[0])
					flags_d = s_axi_wdata[2:0];
			end
			else if (s_axi_awaddr == mrsc_pkg::MRSC_STATUS_OFFSET)
			begin
				if (s_axi_wstrb[0])
					to_d = s_axi_wdata[mrsc_pkg::MRSC_TO_BIT];
			end
			else
				bresp_d = mrsc_pkg::MRSC_RESP_SLVERR;
		end
		// Hardware sets win over software clears
		if (ev_lvr)
			flags_d[mrsc_pkg::MRSC_LOW_VOLTAGE_EVENT_FLAG_BIT] = 1'b1;
		if (ev_lsel)
		begin
			flags_d[mrsc_pkg::MRSC_LRF_BIT] = 1'b1;
			low_voltage_select_d = mrsc_pkg::MRSC_LVS_RESET;
		end
		if (ev_wsel)
			flags_d[mrsc_pkg::MRSC_WRF_BIT] = 1'b1;
		if (ev_wdt)
			to_d = 1'b1;
		if (por_q)
			to_d = 1'b0;
		// Register reads
		if (rd_go)
		begin
			rvalid_d = 1'b1;
			rdata_d  = 32'h0000_0000;
			rresp_d  = mrsc_pkg::MRSC_RESP_OKAY;
			if (s_axi_araddr == mrsc_pkg::MRSC_LVS_OFFSET)
				rdata_d[7:0] = low_voltage_select_q;
			else if (s_axi_araddr == mrsc_pkg::MRSC_FLAGS_OFFSET)
				rdata_d[2:0] = flags_q;
			else if (s_axi_araddr == mrsc_pkg::MRSC_STATUS_OFFSET)
				rdata_d[1:0] = {reset_out.core_reset, to_q};
			else
				rresp_d = mrsc_pkg::MRSC_RESP_SLVERR;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			low_voltage_select_q <= mrsc_pkg::MRSC_LVS_RESET;
			flags_q              <= 3'h0;
			to_q                 <= 1'b0;
			bvalid_q             <= 1'b0;
			bresp_q              <= 2'h0;
			rvalid_q             <= 1'b0;
			rdata_q              <= 32'h0000_0000;
			rresp_q              <= 2'h0;
		end
		else
		begin
			low_voltage_select_q <= low_voltage_select_d;
			flags_q              <= flags_d;
			to_q                 <= to_d;
			bvalid_q             <= bvalid_d;
			bresp_q              <= bresp_d;
			rvalid_q             <= rvalid_d;
			rdata_q              <= rdata_d;
			rresp_q              <= rresp_d;
		end
	end

	// Bus outputs
	assign s_axi_bvalid            = bvalid_q;
	assign s_axi_bresp             = bresp_q;
	assign s_axi_rvalid            = rvalid_q;
	assign s_axi_rdata             = rdata_q;
	assign s_axi_rresp             = rresp_q;
	assign timeout_status_flag_out = to_q;

endmodule
`default_nettype wire

// [core/mrsc_pkg.sv]
//----------------------------------------------------------------------
// Shared constants and types for the reset and reset-source controller
//----------------------------------------------------------------------
package mrsc_pkg;

	// Register byte offsets on the AXI4-Lite bus
	localparam logic [3:0] MRSC_LVS_OFFSET    = 4'h0;
	localparam logic [3:0] MRSC_FLAGS_OFFSET  = 4'h4;
	localparam logic [3:0] MRSC_STATUS_OFFSET = 4'h8;

	// Selection codes
	localparam logic [7:0] MRSC_LVS_ENABLE  = 8'h5A;
	localparam logic [7:0] MRSC_LVS_DISABLE = 8'hA5;
	localparam logic [7:0] MRSC_LVS_RESET   = 8'h5A;

	// Watchdog control codes (five bits)
	localparam logic [4:0] MRSC_WDC_ENABLE  = 5'h0A;
	localparam logic [4:0] MRSC_WDC_DISABLE = 5'h15;

	// Flag field positions in reset_source_flags
	localparam int MRSC_WRF_BIT  = 0;
	localparam int MRSC_LRF_BIT  = 1;
	localparam int MRSC_LOW_VOLTAGE_EVENT_FLAG_BIT = 2;

	// Status register field positions
	localparam int MRSC_TO_BIT   = 0;
	localparam int MRSC_CORE_BIT = 1;

	// Port register reset value
	localparam logic [7:0] MRSC_PORT_RESET = 8'hFF;

	// Timing, in nanoseconds, and the clock period
	localparam int MRSC_CLK_NS        = 10;
	localparam int MRSC_LVR_FILTER_NS = 1000;
	localparam int MRSC_SRESET_NS     = 500;
	localparam int MRSC_RSTD_NS       = 2000;
	// Least times round up to whole cycles
	localparam int MRSC_LVR_FILTER_CYC = (MRSC_LVR_FILTER_NS + MRSC_CLK_NS - 1) / MRSC_CLK_NS;
	localparam int MRSC_SRESET_CYC     = (MRSC_SRESET_NS + MRSC_CLK_NS - 1) / MRSC_CLK_NS;
	localparam int MRSC_RSTD_CYC       = (MRSC_RSTD_NS + MRSC_CLK_NS - 1) / MRSC_CLK_NS;

	// AXI response codes
	localparam logic [1:0] MRSC_RESP_OKAY   = 2'h0;
	localparam logic [1:0] MRSC_RESP_SLVERR = 2'h2;

	// Power modes
	typedef enum logic [1:0]
	{
		MRSC_MODE_FAST  = 2'h0,
		MRSC_MODE_SLOW  = 2'h1,
		MRSC_MODE_IDLE  = 2'h3,
		MRSC_MODE_SLEEP = 2'h2
	} mrsc_mode_type;

	// Reset sequencer states, Gray except WAIT to RUN, which flips both bits
	typedef enum logic [1:0]
	{
		MRSC_ST_RUN  = 2'h0,
		MRSC_ST_HOLD = 2'h1,
		MRSC_ST_WAIT = 2'h3
	} mrsc_state_type;

	// Reset action outputs travel together
	typedef struct packed
	{
		logic core_reset;
		logic pc_clear;
		logic sp_clear;
		logic ports_preset;
	} mrsc_reset_type;

endpackage

// [testbench/mrsc_checker_sva.sv]
`timescale 1ns/10ps
`default_nettype none

module mrsc_checker
#(
	parameter int LVR_FILTER_CYC = 4,
	parameter int RSTD_CYC       = 8
)
(
	input wire logic                     ref_clk_in,
	input wire logic                     rst_n_in,
	input wire logic                     supply_low_in,
	input wire logic                     wdt_overflow_in,
	input wire mrsc_pkg::mrsc_mode_type  power_mode_in,
	input wire mrsc_pkg::mrsc_reset_type reset_out,
	input wire logic                     lvd_enable_out,
	input wire logic                     timeout_status_flag_out,
	input wire logic [3:0]               s_axi_araddr,
	input wire logic                     s_axi_arvalid,
	input wire logic                     s_axi_arready,
	input wire logic [31:0]              s_axi_rdata
);
	logic [15:0] hold_q;
	logic [15:0] hold_d;
	logic [15:0] low_q;
	logic [15:0] low_d;

	// Counts cycles of core reset and of an armed low supply
	always_comb
	begin
		hold_d = reset_out.core_reset ? hold_q + 16'h0001 : 16'h0000;
		low_d = (supply_low_in && lvd_enable_out) ? low_q + 16'h0001 : 16'h0000;
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			hold_q <= 16'h0000;
			low_q <= 16'h0000;
		end
		else
		begin
			hold_q <= hold_d;
			low_q <= low_d;
		end
	end

	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);

	//--------------------------------------------------------------
	// Checks
	//--------------------------------------------------------------
	a_por_start: assert property ($rose(rst_n_in) |-> &reset_out)
		else $error("reset actions not all set after power-on");
	a_core_min_hold: assert property ($fell(reset_out.core_reset) |-> hold_q >= RSTD_CYC)
		else $error("core reset released too early");
	a_supply_reset: assert property (low_q == LVR_FILTER_CYC + 8 |-> reset_out.core_reset)
		else $error("long supply drop gave no reset");
	a_lvd_awake_only: assert property (lvd_enable_out |-> !power_mode_in[1])
		else $error("detection active while asleep");
	a_timeout_flag: assert property ($rose(wdt_overflow_in) |-> ##[1:8] timeout_status_flag_out)
		else $error("timeout flag not set");
	a_full_clears: assert property (reset_out.core_reset |-> reset_out.pc_clear && reset_out.sp_clear)
		else $error("full reset without counter clears");
	a_sleep_pulse: assert property (reset_out.pc_clear && !reset_out.core_reset |=> !reset_out.pc_clear)
		else $error("asleep clear not a single pulse");
	a_upper_zero: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == mrsc_pkg::MRSC_FLAGS_OFFSET
		|=> s_axi_rdata[7:3] == 5'h00)
		else $error("unused flag bits not zero");

	// Main scenarios
	c_full: cover property ($rose(reset_out.core_reset));
	c_asleep: cover property (reset_out.pc_clear && !reset_out.core_reset);
	c_read: cover property (s_axi_arvalid && s_axi_arready);

endmodule

bind mrsc_core mrsc_checker #(.LVR_FILTER_CYC(LVR_FILTER_CYC), .RSTD_CYC(RSTD_CYC)) u_chk
(
	.ref_clk_in, .rst_n_in, .supply_low_in, .wdt_overflow_in, .power_mode_in, .reset_out, .lvd_enable_out,
	.timeout_status_flag_out, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata
);

`default_nettype wire

// [testbench/mrsc_far_side.sv]
`timescale 1ns/10ps
`default_nettype none

// Comparator and watchdog timer standing outside the controller
module mrsc_far_side
(
	// Clock
	input  wire logic ref_clk_in,
	// Event lines
	output logic      supply_low_out,
	output logic      wdt_overflow_out
);

	// Both lines idle inactive
	initial
	begin
		supply_low_out = 1'b0;
		wdt_overflow_out = 1'b0;
	end

	// Supply sits below threshold for n cycles
	task automatic dip(input int n);
		supply_low_out <= 1'b1;
		repeat (n) @(posedge ref_clk_in);
		supply_low_out <= 1'b0;
	endtask

	// Overflow level long enough for the synchroniser
	task automatic overflow();
		wdt_overflow_out <= 1'b1;
		repeat (4) @(posedge ref_clk_in);
		wdt_overflow_out <= 1'b0;
	endtask

endmodule

`default_nettype wire

// [testbench/test_mcu_reset_source_control.sv]
`timescale 1ns/10ps
`default_nettype none

module test_mcu_reset_source_control;
	logic                     ref_clk_in, rst_n_in, sup, ovf, lvd, tof;
	logic                     awv, lane0, awr, wr_r, bv, br, arv, arr, rv, rr;
	logic [4:0]               wdc;
	logic [3:0]               awa, ara, wst;
	logic [31:0]              wd, rd_d;
	logic [1:0]               bresp, rresp;
	logic [7:0]               v;
	mrsc_pkg::mrsc_mode_type  mode;
	mrsc_pkg::mrsc_reset_type ro;
	logic [33:0]              exp_q[$];
	int                       bad_count, n_tests, k, pc_hits;

	mrsc_core #(.LVR_FILTER_CYC(4), .SRESET_CYC(4), .RSTD_CYC(8)) dut
	(
		.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .supply_low_in(sup), .wdt_overflow_in(ovf),
		.wdt_control_in(wdc), .power_mode_in(mode), .reset_out(ro), .lvd_enable_out(lvd),
		.timeout_status_flag_out(tof), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(wst), .s_axi_wvalid(awv), .s_axi_wready(wr_r), .s_axi_bresp(bresp),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rd_d), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr)
	);
	mrsc_far_side far (.ref_clk_in(ref_clk_in), .supply_low_out(sup), .wdt_overflow_out(ovf));

	// Clock
	initial
	begin
		ref_clk_in = 1'b0;
		forever #5 ref_clk_in = ~ref_clk_in;
	end

	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Bounded wait for one handshake or reset level
	task automatic hs(input int w);
		for (k = 0; k < 500; k++)
		begin
			@(posedge ref_clk_in);
			if ((w == 0 && awr && wr_r) || (w == 1 && bv) || (w == 2 && arr) || (w == 5 && rv)
				|| (w == 3 && ro.core_reset) || (w == 4 && !ro.core_reset))
				return;
		end
		bad_count++;
		close_out;
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		awa <= a;
		wd <= d;
		wst <= {3'($urandom), lane0};
		awv <= 1'b1;
		br <= 1'b1;
		hs(0);
		awv <= 1'b0;
		hs(1);
		br <= 1'b0;
		check({32'h0, bresp}, {32'h0, er});
		// Let an edge pass before the next request
		@(posedge ref_clk_in);
	endtask

	task automatic rd(input logic [3:0] a, input logic [33:0] e);
		exp_q.push_back(e);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		hs(2);
		arv <= 1'b0;
		hs(5);
		rr <= 1'b0;
		// Let an edge pass before the next request
		@(posedge ref_clk_in);
	endtask

	task automatic core_is(input logic e);
		check({33'h0, ro.core_reset}, {33'h0, e});
	endtask

	// Read answers checked in order of issue
	always @(posedge ref_clk_in)
	begin
		if (rv && rr)
			check({rresp, rd_d}, exp_q.pop_front());
		if (ro.pc_clear && ro.sp_clear && !ro.core_reset)
			pc_hits++;
	end

	initial
	begin
		{rst_n_in, awv, br, arv, rr, awa, ara, wd} = '0;
		lane0 = 1'b1;
		{bad_count, n_tests, pc_hits} = '0;
		wst = 4'hF;
		wdc = 5'h0A;
		mode = mrsc_pkg::MRSC_MODE_FAST;
		k = $urandom(65670);
		repeat (16) @(posedge ref_clk_in);
		check({30'h0, ro}, 34'h00000000F);
		rst_n_in <= 1'b1;
		hs(4);
		rd(4'h0, 34'h05A);
		rd(4'h4, 34'h000);
		far.dip(2);
		repeat (20) @(posedge ref_clk_in);
		core_is(1'b0);
		$display("power-on and short dip done");
		far.dip(12);
		hs(3);
		hs(4);
		rd(4'h4, 34'h004);
		rd(4'h0, 34'h05A);
		wr(4'h4, $urandom & 32'h000000F8, 2'h0);
		rd(4'h4, 34'h000);
		// Write without byte lane zero leaves the select code alone
		lane0 = 1'b0;
		wr(4'h0, 32'h000000A5, 2'h0);
		lane0 = 1'b1;
		rd(4'h0, 34'h05A);
		wr(4'h0, 32'h000000A5, 2'h0);
		check({33'h0, lvd}, 34'h0);
		far.dip(20);
		core_is(1'b0);
		wr(4'h0, 32'h0000005A, 2'h0);
		mode <= mrsc_pkg::mrsc_mode_type'({1'b1, 1'($urandom)});
		far.dip(20);
		core_is(1'b0);
		far.overflow();
		repeat (8) @(posedge ref_clk_in);
		core_is(1'b0);
		check(pc_hits, 34'h1);
		check({33'h0, tof}, 34'h1);
		rd(4'h8, 34'h001);
		$display("supply and asleep timeout done");
		mode <= mrsc_pkg::mrsc_mode_type'({1'b0, 1'($urandom)});
		far.overflow();
		hs(3);
		hs(4);
		rd(4'h8, 34'h001);
		do v = 8'($urandom); while (v == 8'h5A || v == 8'hA5);
		wr(4'h0, {24'h0, v}, 2'h0);
		repeat (2) @(posedge ref_clk_in);
		core_is(1'b0);
		hs(3);
		hs(4);
		rd(4'h4, 34'h002);
		rd(4'h0, 34'h05A);
		do v = 8'($urandom & 31); while (v == 8'h0A || v == 8'h15);
		wdc <= v[4:0];
		hs(3);
		wdc <= 5'h0A;
		hs(4);
		rd(4'h4, 34'h003);
		rd(4'hC, {mrsc_pkg::MRSC_RESP_SLVERR, 32'h0});
		wr(4'hC, 32'h00000001, mrsc_pkg::MRSC_RESP_SLVERR);
		$display("selection, watchdog code and bus done");
		close_out;
	end

endmodule

`default_nettype wire
